// ---- rtl/gtw_slave.sv ----
// slave end of the two-wire port: address match, byte framing, ack, stretch
`timescale 1ns/10ps
`include "gtw_params.svh"
module gtw_slave
    import gtw_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // link
    gtw_link_if.slave link,
    // received bytes
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic frame_done,
    // bytes to return to the master
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic tx_taken,
    // status
    output logic busy,
    output logic bad_frame
);
    ////////////////////////////////////////////////////////////////////
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;
    gtw_slv_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] txreg;
    logic rd_mode;
    logic bits_seen;
    logic ack_drive;
    logic stretch;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic busy_load;

    // two flops on each pin before any logic sees it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], link.scl};
            sda_sync <= {sda_sync[0], link.sda};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
        end
    end

    assign scl_s = scl_sync[1];
    assign sda_s = sda_sync[1];
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    // sda edges with scl high are never data
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

    // framing state machine, runs only on master edges
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= GTW_S_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            rd_mode <= 1'b0;
            bits_seen <= 1'b0;
        end else if (start_det) begin
            state <= GTW_S_ADDR;
            bit_cnt <= 4'h0;
            bits_seen <= 1'b0;
        end else if (stop_det) begin
            state <= GTW_S_IDLE; // partial shreg simply dropped
        end else if (scl_rise) begin
            case (state)
                GTW_S_ADDR, GTW_S_RX: begin
                    shreg <= {shreg[6:0], sda_s};
                    bit_cnt <= bit_cnt + 4'h1;
                    bits_seen <= 1'b1;
                end
                GTW_S_TX: begin
                    bit_cnt <= bit_cnt + 4'h1;
                    bits_seen <= 1'b1;
                end
                GTW_S_TACK: begin
                    // master nack ends the read stream
                    state <= sda_s ? GTW_S_IGNORE : GTW_S_TX;
                    bit_cnt <= 4'h0;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state)
                GTW_S_ADDR: begin
                    if (bit_cnt == 4'h8) begin
                        rd_mode <= shreg[0];
                        state <= (shreg[7:1] == `GTW_DEV_ADDR) ? GTW_S_AACK
                                                              : GTW_S_IGNORE;
                    end
                end
                GTW_S_RX: begin
                    if (bit_cnt == 4'h8) begin
                        state <= GTW_S_RACK;
                    end
                end
                GTW_S_AACK, GTW_S_RACK: begin
                    bit_cnt <= 4'h0;
                    state <= rd_mode ? GTW_S_TX : GTW_S_RX;
                end
                GTW_S_TX: begin
                    if (bit_cnt == 4'h8) begin
                        state <= GTW_S_TACK;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ack pulled during ninth clock of address and write bytes
    assign ack_drive = (state == GTW_S_AACK) | (state == GTW_S_RACK);

    // clock stretch while a read byte has no data ready yet
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stretch <= 1'b0;
            txreg <= 8'h00;
            tx_taken <= 1'b0;
        end else begin
            tx_taken <= 1'b0;
            if (state == GTW_S_TX && bit_cnt == 4'h0 && !scl_s && !stretch
                && !tx_taken && !busy_load) begin
                stretch <= 1'b1;
            end
            if (stretch && tx_ready) begin
                stretch <= 1'b0;
                txreg <= tx_data;
                tx_taken <= 1'b1;
            end else if (scl_fall && state == GTW_S_TX) begin
                txreg <= {txreg[6:0], 1'b1};
            end
            if (start_det || stop_det) begin
                stretch <= 1'b0;
            end
        end
    end

    // one byte loaded per tx byte slot
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy_load <= 1'b0;
        end else if (tx_taken) begin
            busy_load <= 1'b1;
        end else if (state != GTW_S_TX || bit_cnt != 4'h0) begin
            busy_load <= 1'b0;
        end
    end

    // open-drain drivers, released except to pull low; the first read bit goes
    // out with tx_taken, a cycle before the stretch ends, so it is set up before scl rises
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            link.sda_s_oe <= 1'b0;
            link.scl_s_oe <= 1'b0;
        end else begin
            link.scl_s_oe <= stretch | (state == GTW_S_TX && bit_cnt == 4'h0
                             && !scl_s && !busy_load);
            if (ack_drive) begin
                link.sda_s_oe <= 1'b1;
            end else if (state == GTW_S_TX && (tx_taken | busy_load | (bit_cnt != 4'h0))) begin
                link.sda_s_oe <= ~txreg[7];
            end else begin
                link.sda_s_oe <= 1'b0;
            end
        end
    end

    // completed and acknowledged bytes only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            frame_done <= 1'b0;
            bad_frame <= 1'b0;
            busy <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            frame_done <= 1'b0;
            bad_frame <= 1'b0;
            if (scl_fall && state == GTW_S_RACK) begin
                rx_data <= shreg;
                rx_valid <= 1'b1;
            end
            if (stop_det && state != GTW_S_IDLE) begin
                frame_done <= bits_seen;
                bad_frame <= ~bits_seen;
            end
            busy <= (state != GTW_S_IDLE) & ~stop_det;
        end
    end
endmodule

// ---- shared/gtw_params.svh ----
// constants for the two-wire slave port and its master end
`ifndef GTW_PARAMS_SVH
`define GTW_PARAMS_SVH
`define GTW_ADDR_W 7
`define GTW_BYTE_W 8
`define GTW_DEV_ADDR 7'h55
`define GTW_CLK_MHZ 250
`define GTW_SCL_KHZ 100
// half period of the master's clock in ref_clk cycles
`define GTW_HALF_CYC ((`GTW_CLK_MHZ * 1000) / (`GTW_SCL_KHZ * 2))
`define GTW_CNT_W 11
`endif

// ---- shared/gtw_pkg.sv ----
// types shared by both ends of the two-wire link
package gtw_pkg;
    typedef enum logic [2:0] {
        GTW_S_IDLE,
        GTW_S_ADDR,
        GTW_S_AACK,
        GTW_S_RX,
        GTW_S_RACK,
        GTW_S_TX,
        GTW_S_TACK,
        GTW_S_IGNORE
    } gtw_slv_state_t;
    typedef enum logic [2:0] {
        GTW_M_IDLE,
        GTW_M_START,
        GTW_M_LOW,
        GTW_M_HIGH,
        GTW_M_STOP0,
        GTW_M_STOP1,
        GTW_M_DONE
    } gtw_mst_state_t;
endpackage

// ---- shared/gtw_link_if.sv ----
// two-wire link between master and slave, wired-and of open-drain drivers
`timescale 1ns/10ps
interface gtw_link_if;
    logic scl_m_oe;
    logic sda_m_oe;
    logic scl_s_oe;
    logic sda_s_oe;
    logic scl;
    logic sda;
    // pull-up makes each line high unless some party pulls it low
    assign scl = ~(scl_m_oe | scl_s_oe);
    assign sda = ~(sda_m_oe | sda_s_oe);
    modport slave (input scl, input sda, output scl_s_oe, output sda_s_oe);
    modport master (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface

// ---- rtl/gtw_master.sv ----
// master end of the two-wire link: one addressed transfer per request
`timescale 1ns/10ps
`include "gtw_params.svh"
module gtw_master
    import gtw_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // link
    gtw_link_if.master link,
    // request
    input wire logic req,
    input wire logic [6:0] req_addr,
    input wire logic req_read,
    input wire logic [7:0] req_wdata,
    // answer
    output logic done,
    output logic acked,
    output logic [7:0] rdata
);
    ////////////////////////////////////////////////////////////////////
    localparam logic [10:0] HALF = 11'(`GTW_HALF_CYC);
    gtw_mst_state_t state;
    logic [10:0] cnt;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [3:0] bitn;
    logic byte2;
    logic [8:0] sh;
    logic rd;
    logic ok;

    // pins synchronised before use
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
        end else begin
            scl_sync <= {scl_sync[0], link.scl};
            sda_sync <= {sda_sync[0], link.sda};
        end
    end

    // bit engine: 9-bit slots, address then one data byte
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= GTW_M_IDLE;
            cnt <= 11'h0;
            bitn <= 4'h0;
            byte2 <= 1'b0;
            sh <= 9'h1ff;
            rd <= 1'b0;
            ok <= 1'b0;
            rdata <= 8'h00;
            done <= 1'b0;
            acked <= 1'b0;
            link.scl_m_oe <= 1'b0;
            link.sda_m_oe <= 1'b0;
        end else begin
            done <= 1'b0;
            cnt <= (cnt == 11'h0) ? 11'h0 : cnt - 11'h1;
            case (state)
                GTW_M_IDLE: begin
                    if (req) begin
                        sh <= {req_addr, req_read, 1'b1};
                        rd <= req_read;
                        byte2 <= 1'b0;
                        bitn <= 4'h0;
                        ok <= 1'b1;
                        link.sda_m_oe <= 1'b1; // start: sda falls, scl high
                        cnt <= HALF;
                        state <= GTW_M_START;
                    end
                end
                GTW_M_START: begin
                    if (cnt == 11'h0) begin
                        link.scl_m_oe <= 1'b1;
                        cnt <= HALF;
                        state <= GTW_M_LOW;
                    end
                end
                GTW_M_LOW: begin
                    if (cnt == HALF - 11'h1) begin
                        link.sda_m_oe <= ~sh[8];
                    end
                    if (cnt == 11'h0) begin
                        link.scl_m_oe <= 1'b0;
                        state <= GTW_M_HIGH;
                    end
                end
                GTW_M_HIGH: begin
                    // wait here while the slave stretches the clock
                    if (scl_sync[1] && cnt == 11'h0) begin
                        cnt <= HALF;
                    end else if (scl_sync[1] && cnt == 11'h1) begin
                        if (bitn == 4'h8) begin
                            // the ack slot of a read byte carries the master's own nack
                            ok <= ok & (~sda_sync[1] | (byte2 & rd));
                        end else if (byte2 && rd) begin
                            rdata <= {rdata[6:0], sda_sync[1]};
                        end
                        link.scl_m_oe <= 1'b1;
                        cnt <= HALF;
                        sh <= {sh[7:0], 1'b1};
                        bitn <= bitn + 4'h1;
                        state <= GTW_M_LOW;
                        if (bitn == 4'h8) begin
                            bitn <= 4'h0;
                            byte2 <= 1'b1;
                            sh <= (rd | ~(ok & ~sda_sync[1])) ? {8'hff, ~rd | 1'b1}
                                  : {req_wdata, 1'b1};
                            if (byte2 || !(ok & ~sda_sync[1])) begin
                                state <= GTW_M_STOP0;
                            end
                        end else if (byte2 && rd && bitn == 4'h7) begin
                            sh <= 9'h1ff; // nack last read byte
                        end
                    end
                end
                GTW_M_STOP0: begin
                    if (cnt == HALF - 11'h1) begin
                        link.sda_m_oe <= 1'b1;
                    end
                    if (cnt == 11'h0) begin
                        link.scl_m_oe <= 1'b0;
                        cnt <= HALF;
                        state <= GTW_M_STOP1;
                    end
                end
                GTW_M_STOP1: begin
                    if (cnt == 11'h0) begin
                        link.sda_m_oe <= 1'b0; // stop: sda rises, scl high
                        cnt <= HALF;
                        state <= GTW_M_DONE;
                    end
                end
                GTW_M_DONE: begin
                    if (cnt == 11'h0) begin
                        done <= 1'b1;
                        acked <= ok;
                        state <= GTW_M_IDLE;
                    end
                end
                default: begin
                    state <= GTW_M_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- tb/gtw_link_checker.sv ----
// concurrent checks on the two-wire link between master and slave
`timescale 1ns/10ps
`include "gtw_params.svh"
module gtw_link_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // open-drain enables
    input wire logic scl_m_oe,
    input wire logic sda_m_oe,
    input wire logic scl_s_oe,
    input wire logic sda_s_oe,
    // resolved lines
    input wire logic scl,
    input wire logic sda
);
    logic p_scl;
    logic p_sda;
    logic first;
    logic rd;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic start_c;
    logic stop_c;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // start and stop as seen on the wires
    assign start_c = scl & p_scl & p_sda & ~sda;
    assign stop_c = scl & p_scl & ~p_sda & sda;
    // previous line levels
    always_ff @(posedge ref_clk) begin
        p_scl <= scl;
        p_sda <= sda;
    end
    // rising edges since start; every start restarts the count, so sr needs no extra case
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt <= 4'h0;
            first <= 1'b0;
            rd <= 1'b0;
            sh <= 8'h00;
        end else if (start_c) begin
            cnt <= 4'h0;
            first <= 1'b1;
        end else if (scl && !p_scl) begin
            cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
            sh <= {sh[6:0], sda};
            if (first && cnt == 4'h7) rd <= sda;
            if (cnt == 4'h8) first <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_ninth;
        $rose(scl) && cnt == 4'h8;
    endsequence
    sequence s_stop;
        stop_c;
    endsequence
    property p_rst_idle;
        $fell(rst) |-> !scl_s_oe && !sda_s_oe && !scl_m_oe && !sda_m_oe;
    endproperty
    property p_stable;
        scl && $past(scl) |-> $stable(sda_s_oe);
    endproperty
    property p_rose_low;
        $rose(sda_s_oe) |-> !scl;
    endproperty
    property p_stretch;
        $rose(scl_s_oe) |-> scl_m_oe && !scl;
    endproperty
    property p_addr_ack;
        s_ninth ##0 first |-> sda_s_oe == (sh[7:1] == `GTW_DEV_ADDR);
    endproperty
    property p_first_quiet;
        $rose(scl) && first && cnt != 4'h8 |-> !sda_s_oe;
    endproperty
    property p_wr_quiet;
        $rose(scl) && !first && !rd && cnt != 4'h8 |-> !sda_s_oe;
    endproperty
    property p_rd_nack;
        s_ninth ##0 (!first && rd) |-> !sda_s_oe;
    endproperty
    property p_stop_idle;
        s_stop |=> (!sda_s_oe && !scl_s_oe) [*8];
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("lines not released after reset");
    a_stable: assert property (p_stable) else $error("slave sda moved while scl high");
    a_rose_low: assert property (p_rose_low) else $error("slave pulled sda with scl high");
    a_stretch: assert property (p_stretch) else $error("slave stretch began with scl high");
    a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
    a_first_quiet: assert property (p_first_quiet) else $error("slave drove address bit");
    a_wr_quiet: assert property (p_wr_quiet) else $error("slave drove write data bit");
    a_rd_nack: assert property (p_rd_nack) else $error("slave drove master ack slot");
    a_stop_idle: assert property (p_stop_idle) else $error("slave drove after stop");
endmodule

// ---- tb/gauge_two_wire_slave_port_bench.sv ----
// self-checking bench joining master and slave ends of the two-wire link
`timescale 1ns/10ps
`include "gtw_params.svh"
module gauge_two_wire_slave_port_bench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic req_read = 1'b0;
    logic tx_ready = 1'b0;
    logic [6:0] req_addr = 7'h00;
    logic [7:0] req_wdata = 8'h00;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] rx_data;
    logic [7:0] rdata;
    logic rx_valid;
    logic frame_done;
    logic tx_taken;
    logic done;
    logic acked;
    logic busy;
    logic bad_frame;
    logic [9:0] m_q[$];
    logic [7:0] s_q[$];
    logic [9:0] e;
    logic [31:0] r;
    int err_count = 0;
    int samples_checked = 0;
    int seed = 31;
    int n;
    int frames = 0;
    int taken = 0;
    int bads = 0;
    gtw_link_if link();
    gtw_slave u_gtw_slave (.ref_clk(ref_clk), .rst(rst), .link(link), .rx_data(rx_data),
        .rx_valid(rx_valid), .frame_done(frame_done), .tx_data(tx_data),
        .tx_ready(tx_ready), .tx_taken(tx_taken), .busy(busy), .bad_frame(bad_frame));
    gtw_master u_gtw_master (.ref_clk(ref_clk), .rst(rst), .link(link), .req(req),
        .req_addr(req_addr), .req_read(req_read), .req_wdata(req_wdata), .done(done),
        .acked(acked), .rdata(rdata));
    gtw_link_checker u_gtw_link_checker (.ref_clk(ref_clk), .rst(rst),
        .scl_m_oe(link.scl_m_oe), .sda_m_oe(link.sda_m_oe), .scl_s_oe(link.scl_s_oe),
        .sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda));
    ////////////////////////////////////////////////////////////////////////////////
    // 250 mhz reference clock
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    task check(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("checks=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // one request; the note is filed before the answer can appear
    task xfer(input logic [6:0] a, input logic rd, input logic [7:0] d, input logic ack);
        int k;
        @(negedge ref_clk);
        req_addr = a;
        req_read = rd;
        req_wdata = d;
        req = 1'b1;
        m_q.push_back({rd, ack, d});
        @(negedge ref_clk);
        req = 1'b0;
        for (k = 0; k < 70000 && done !== 1'b1; k++) @(negedge ref_clk);
        check({9'h000, done}, 10'h001);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // rdata only counts on reads, writes leave it unchanged
    always @(posedge ref_clk) begin
        #1;
        if (done === 1'b1) begin
            e = m_q.pop_front();
            check({e[9], acked, e[9] ? rdata : e[7:0]}, e);
        end
        if (rx_valid === 1'b1) check({2'b00, rx_data}, {2'b00, s_q.pop_front()});
        if (frame_done === 1'b1) frames++;
        if (tx_taken === 1'b1) taken++;
        if (bad_frame === 1'b1) bads++;
    end
    // watchdog sized for three byte frames at 100 khz plus a stall
    initial begin
        #1000000;
        err_count++;
        wrap_up;
    end
    initial begin
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        check({8'h00, link.scl, link.sda}, 10'h003);
        r = $random(seed);
        s_q.push_back(r[7:0]);
        xfer(`GTW_DEV_ADDR, 1'b0, r[7:0], 1'b1);
        $display("write to own address done");
        r = $random(seed);
        tx_data = r[7:0];
        fork
            xfer(`GTW_DEV_ADDR, 1'b1, r[7:0], 1'b1);
            begin
                for (n = 0; n < 40000 && link.scl_s_oe !== 1'b1; n++) @(negedge ref_clk);
                repeat (3000) @(negedge ref_clk);
                check({9'h000, link.scl}, 10'h000);
                check({9'h000, busy}, 10'h001);
                tx_ready = 1'b1;
            end
        join
        tx_ready = 1'b0;
        $display("stretched read done");
        r = $random(seed);
        xfer(`GTW_DEV_ADDR ^ 7'h7f, 1'b0, r[7:0], 1'b0);
        $display("foreign address done");
        repeat (20) @(negedge ref_clk);
        check({8'h00, link.scl, link.sda}, 10'h003);
        check(10'(frames), 10'h003);
        check(10'(taken), 10'h001);
        check(10'(bads), 10'h000);
        check({9'h000, busy}, 10'h000);
        check(10'(m_q.size()), 10'h000);
        check(10'(s_q.size()), 10'h000);
        wrap_up;
    end
endmodule
